/* inc/ddwd_pkg.sv */
/*
  Shared constants and carrier types for the dual DAC word decoder.
  Assumes a 16-bit serial command word, MSB first, and a 12-bit data field.
*/
`default_nettype none

package ddwd_pkg;

  // Word geometry
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 12;

  // Bit counter: reset value and index of the last bit of a word
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_LAST = 4'hF;

  // Target select codes, high bit then low bit
  localparam logic [1:0] SEL_B_AND_BUF = 2'h0;
  localparam logic [1:0] SEL_BUF_ONLY = 2'h1;
  localparam logic [1:0] SEL_A_AND_B = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;

  // Reference select field codes
  localparam logic [1:0] REF_EXT_LO = 2'h0;
  localparam logic [1:0] REF_INT_1V = 2'h1;
  localparam logic [1:0] REF_INT_2V = 2'h2;
  localparam logic [1:0] REF_EXT_HI = 2'h3;

  // Reset values
  localparam logic [11:0] DATA_RST = 12'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [2:0] SYNC_RST_LO = 3'h0;
  localparam logic [2:0] SYNC_RST_HI = 3'h7;

  // Decoded reference source, one-hot
  typedef enum logic [2:0] {
    VREF_EXTERNAL = 3'b001,
    VREF_INT_1V024 = 3'b010,
    VREF_INT_2V048 = 3'b100
  } ddwd_vref_e;

  // Command word laid out at its bit positions
  typedef struct packed {
    logic targetSelectHigh;
    logic settlingSpeedBit;
    logic powerDownBit;
    logic targetSelectLow;
    logic [11:0] data;
  } ddwd_word_s;

  // Link-domain view handed to the core domain
  typedef struct packed {
    logic toggle;
    logic [3:0] count;
    logic [15:0] shift;
    logic [15:0] hold;
  } ddwd_link_s;

endpackage

`default_nettype wire

/* logic/ddwd_link_shifter.sv */
/*
  Serial shifter on the link clock: samples data on falling serial clock edges.
  Assumes the host only toggles the serial clock while chip select is low.
*/
`timescale 1ns/1ps
`default_nettype none

module ddwd_link_shifter (
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_sdi,
  input wire logic rst_b,
  output ddwd_pkg::ddwd_link_s linkState
);
  import ddwd_pkg::*;

  ddwd_link_s st_ff;
  ddwd_link_s nxt_st;
  logic inFrame_ff;
  logic frameRstB;
  logic [3:0] baseCount;
  logic [15:0] newShift;

  // Frame flag ends with the frame itself, no clock edge needed
  assign frameRstB = rst_b & ~link_cs_n;

  always_ff @(negedge link_sclk or negedge frameRstB) begin
    if (!frameRstB) begin
      inFrame_ff <= 1'b0;
    end else begin
      inFrame_ff <= 1'b1;
    end
  end

  // Shift MSB first, wrap every sixteen bits
  always_comb begin
    nxt_st = st_ff;
    baseCount = inFrame_ff ? st_ff.count : CNT_RST;
    newShift = {st_ff.shift[14:0], link_sdi};
    if (!link_cs_n) begin
      nxt_st.shift = newShift;
      if (baseCount == CNT_LAST) begin
        // Word held stable for the core while the next one shifts in
        nxt_st.count = CNT_RST;
        nxt_st.hold = newShift;
        nxt_st.toggle = ~st_ff.toggle;
      end else begin
        nxt_st.count = 4'(baseCount + 4'h1);
      end
    end
  end

  always_ff @(negedge link_sclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{toggle: 1'b0, count: CNT_RST, shift: WORD_RST, hold: WORD_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign linkState = st_ff;

  chk_word_wrap: assert property (@(negedge link_sclk) disable iff (!rst_b)
    (!link_cs_n && inFrame_ff && st_ff.count == CNT_LAST) |=>
      (st_ff.count == CNT_RST && st_ff.toggle != $past(st_ff.toggle)))
    else $error("link word did not complete at sixteen bits");

endmodule

`default_nettype wire

/* logic/ddwd_word_sync.sv */
/*
  Brings the word toggle and chip select into the core clock domain.
  Assumes the link word register stays stable while its toggle is crossing.
*/
`timescale 1ns/1ps
`default_nettype none

module ddwd_word_sync (
  input wire logic core_clk,
  input wire logic rstB,
  input wire logic clk_en,
  input wire logic toggleIn,
  input wire logic link_cs_n,
  output logic wordPulse,
  output logic csRisePulse
);
  import ddwd_pkg::*;

  typedef struct packed {
    logic [2:0] tgl;
    logic [2:0] cs;
    logic tglSeen;
    logic csSeen;
    logic wordPulse;
    logic csRisePulse;
  } ddwd_sync_s;

  ddwd_sync_s st_ff;
  ddwd_sync_s nxt_st;

  // Three stages; a change counts once stages two and three agree
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tgl = {st_ff.tgl[1:0], toggleIn};
    nxt_st.cs = {st_ff.cs[1:0], link_cs_n};
    nxt_st.wordPulse = 1'b0;
    nxt_st.csRisePulse = 1'b0;
    if (st_ff.tgl[1] == st_ff.tgl[2] && st_ff.tgl[2] != st_ff.tglSeen) begin
      nxt_st.tglSeen = st_ff.tgl[2];
      nxt_st.wordPulse = 1'b1;
    end
    if (st_ff.cs[1] == st_ff.cs[2] && st_ff.cs[2] != st_ff.csSeen) begin
      nxt_st.csSeen = st_ff.cs[2];
      nxt_st.csRisePulse = st_ff.cs[2]; // Only the rising edge ends a frame
    end
  end

  always_ff @(posedge core_clk or negedge rstB) begin
    if (!rstB) begin
      st_ff <= '{tgl: SYNC_RST_LO, cs: SYNC_RST_HI, tglSeen: 1'b0, csSeen: 1'b1,
                 wordPulse: 1'b0, csRisePulse: 1'b0};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign wordPulse = st_ff.wordPulse;
  assign csRisePulse = st_ff.csRisePulse;

  chk_cs_rise_single: assert property (@(posedge core_clk) disable iff (!rstB)
    (clk_en && csRisePulse) |=> !csRisePulse)
    else $error("chip select rise reported twice");

endmodule

`default_nettype wire

/* logic/dual_dac_word_decoder.sv */
/*
  Command decoder for a dual 12-bit DAC: latches, holding buffer, reference control.
  Assumes a host that drives chip select, serial clock and data per the link timing.
*/
`timescale 1ns/1ps
`default_nettype none

module dual_dac_word_decoder (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_sdi,
  output logic [11:0] dac_a_code,
  output logic [11:0] dac_b_code,
  output logic dac_a_load,
  output logic dac_b_load,
  output logic fast_settle,
  output logic power_down,
  output ddwd_pkg::ddwd_vref_e vref_sel
);
  import ddwd_pkg::*;

  typedef struct packed {
    ddwd_word_s word;
    logic pending;
    logic [11:0] chanA;
    logic [11:0] chanB;
    logic [11:0] buffer;
    logic [11:0] ctrl;
    logic fast;
    logic pwrDown;
    ddwd_vref_e vref;
    logic loadA;
    logic loadB;
  } ddwd_core_s;

  ddwd_core_s st_ff;
  ddwd_core_s nxt_st;
  logic [1:0] rstSync_ff;
  logic rstSyncB;
  ddwd_link_s linkState;
  logic wordPulse;
  logic csRisePulse;
  logic [1:0] selCode;

  // Reference field decode, shared by the update path and its checks
  function automatic ddwd_vref_e refDecode(input logic vrefSelectHigh,
                                           input logic vrefSelectLow);
    unique case ({vrefSelectHigh, vrefSelectLow})
      REF_INT_1V: refDecode = VREF_INT_1V024;
      REF_INT_2V: refDecode = VREF_INT_2V048;
      REF_EXT_LO, REF_EXT_HI: refDecode = VREF_EXTERNAL;
    endcase
  endfunction

  // Target select code from a command word
  function automatic logic [1:0] selOf(input ddwd_word_s w);
    selOf = {w.targetSelectHigh, w.targetSelectLow};
  endfunction

  // Reset released through two stages so all flops leave reset together
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_ff <= 2'b00;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstSyncB = rstSync_ff[1];

  ddwd_link_shifter u_shifter (
    .link_sclk(link_sclk),
    .link_cs_n(link_cs_n),
    .link_sdi(link_sdi),
    .rst_b(rstSyncB),
    .linkState(linkState)
  );

  ddwd_word_sync u_sync (
    .core_clk(core_clk),
    .rstB(rstSyncB),
    .clk_en(clk_en),
    .toggleIn(linkState.toggle),
    .link_cs_n(link_cs_n),
    .wordPulse(wordPulse),
    .csRisePulse(csRisePulse)
  );

  assign selCode = selOf(st_ff.word);

  // Capture a word, then apply it one cycle later; both stages run every cycle that clk_en is high
  always_comb begin
    nxt_st = st_ff;
    nxt_st.loadA = 1'b0;
    nxt_st.loadB = 1'b0;
    nxt_st.pending = 1'b0;
    if (st_ff.pending) begin
      if (st_ff.word.powerDownBit) begin
        nxt_st.pwrDown = 1'b1;
      end else begin
        nxt_st.pwrDown = 1'b0;
        nxt_st.fast = st_ff.word.settlingSpeedBit;
        unique case (selCode)
          SEL_B_AND_BUF: begin
            nxt_st.chanB = st_ff.word.data;
            nxt_st.buffer = st_ff.word.data;
            nxt_st.loadB = 1'b1;
          end
          SEL_BUF_ONLY: begin
            nxt_st.buffer = st_ff.word.data;
          end
          SEL_A_AND_B: begin
            // Old buffer goes to channel B in the same edge as channel A
            nxt_st.chanA = st_ff.word.data;
            nxt_st.chanB = st_ff.buffer;
            nxt_st.loadA = 1'b1;
            nxt_st.loadB = 1'b1;
          end
          SEL_CTRL: begin
            nxt_st.ctrl = st_ff.word.data;
            nxt_st.vref = refDecode(st_ff.word.data[1], st_ff.word.data[0]);
          end
        endcase
      end
    end
    // Full word wins; an early chip select rise moves a partial word as shifted
    if (wordPulse) begin
      nxt_st.word = linkState.hold;
      nxt_st.pending = 1'b1;
    end else if (csRisePulse && linkState.count != CNT_RST) begin
      nxt_st.word = linkState.shift;
      nxt_st.pending = 1'b1;
    end
  end

  // Power-on clears every latch; control is only touched by control writes
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      st_ff <= '{word: WORD_RST, pending: 1'b0, chanA: DATA_RST, chanB: DATA_RST,
                 buffer: DATA_RST, ctrl: DATA_RST, fast: 1'b0, pwrDown: 1'b0,
                 vref: VREF_EXTERNAL, loadA: 1'b0, loadB: 1'b0};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state flops
  assign dac_a_code = st_ff.chanA;
  assign dac_b_code = st_ff.chanB;
  assign dac_a_load = st_ff.loadA;
  assign dac_b_load = st_ff.loadB;
  assign fast_settle = st_ff.fast;
  assign power_down = st_ff.pwrDown;
  assign vref_sel = st_ff.vref;

  chk_word_taken: assert property (@(posedge core_clk) disable iff (!rstSyncB)
    (clk_en && wordPulse) |=> (st_ff.pending && st_ff.word == $past(linkState.hold)))
    else $error("completed word not captured");

  chk_load_b_buf: assert property (@(posedge core_clk) disable iff (!rstSyncB)
    (clk_en && st_ff.pending && !st_ff.word.powerDownBit && selCode == SEL_B_AND_BUF) |=>
      (dac_b_load && dac_b_code == $past(st_ff.word.data) &&
       st_ff.buffer == $past(st_ff.word.data) && $stable(dac_a_code)))
    else $error("channel B and buffer load wrong");

  chk_buffer_only: assert property (@(posedge core_clk) disable iff (!rstSyncB)
    (clk_en && st_ff.pending && !st_ff.word.powerDownBit && selCode == SEL_BUF_ONLY) |=>
      ($stable(dac_a_code) && $stable(dac_b_code) && !dac_a_load && !dac_b_load &&
       st_ff.buffer == $past(st_ff.word.data)))
    else $error("buffer-only write disturbed a channel");

  chk_both_update: assert property (@(posedge core_clk) disable iff (!rstSyncB)
    (clk_en && st_ff.pending && !st_ff.word.powerDownBit && selCode == SEL_A_AND_B) |=>
      (dac_a_load && dac_b_load && dac_a_code == $past(st_ff.word.data) &&
       dac_b_code == $past(st_ff.buffer)))
    else $error("simultaneous update of both channels wrong");

  chk_ctrl_ref: assert property (@(posedge core_clk) disable iff (!rstSyncB)
    (clk_en && st_ff.pending && !st_ff.word.powerDownBit && selCode == SEL_CTRL) |=>
      (vref_sel == refDecode($past(st_ff.word.data[1]), $past(st_ff.word.data[0])) &&
       $stable(dac_a_code) && $stable(dac_b_code)))
    else $error("reference select decode wrong");

  chk_ref_kept: assert property (@(posedge core_clk) disable iff (!rstSyncB)
    (!(st_ff.pending && !st_ff.word.powerDownBit && selCode == SEL_CTRL)) |=>
      $stable(vref_sel))
    else $error("reference setting changed without control write");

  chk_pwr_only: assert property (@(posedge core_clk) disable iff (!rstSyncB)
    (clk_en && st_ff.pending && st_ff.word.powerDownBit) |=>
      (power_down && $stable(dac_a_code) && $stable(dac_b_code) &&
       $stable(fast_settle) && $stable(vref_sel)))
    else $error("power-down word touched other state");

  chk_speed_each: assert property (@(posedge core_clk) disable iff (!rstSyncB)
    (clk_en && st_ff.pending && !st_ff.word.powerDownBit) |=>
      (!power_down && fast_settle == $past(st_ff.word.settlingSpeedBit)))
    else $error("speed or power bit not applied");

  chk_reset_clear: assert property (@(posedge core_clk)
    $rose(rstSyncB) |-> (dac_a_code == DATA_RST && dac_b_code == DATA_RST &&
                         st_ff.buffer == DATA_RST && !power_down))
    else $error("latches not cleared at power-on");

endmodule

`default_nettype wire

/* test/ddwd_host_model.sv */
/*
  Host serial port model: drives chip select, serial clock and data, MSB first.
  Assumes the bench calls xfer only after reset release plus three core cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module ddwd_host_model (
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_sdi
);
  localparam realtime HALF = 62.5;

  // Idle: clock parked high, no frame, data line driven low
  initial begin
    link_sclk = 1'b1;
    link_cs_n = 1'b1;
    link_sdi = 1'b0;
  end

  // Reference pin is never driven here, so any select code is legal
  // Sends n bits of w, one bit at a time on link_sdi, with a pause after each bit whose index in w is a multiple of eight
  task automatic xfer(input logic [31:0] w, input int n);
    #(3.1);
    link_cs_n = 1'b0; // Falling select opens the frame
    #(HALF);
    for (int i = n - 1; i >= 0; i--) begin
      link_sdi = w[i]; // MSB first, 16-bit words
      #(HALF);
      link_sclk = 1'b0;
      #(HALF);
      link_sclk = 1'b1;
      if (i % 8 == 0) begin
        #(2 * HALF); // Gap between bytes, select held low
      end
    end
    link_cs_n = 1'b1;
    link_sdi = ~link_sdi; // Released line must not look like held data
  endtask
endmodule

`default_nettype wire

/* test/dual_dac_word_decoder_bench.sv */
/*
  Self-checking bench for the dual DAC word decoder, driven through the host model.
  Assumes the design package is compiled first and outputs settle within 12 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module dual_dac_word_decoder_bench;
  import ddwd_pkg::*;
  logic core_clk;
  logic rst_b;
  logic clk_en;
  wire logic link_sclk;
  wire logic link_cs_n;
  wire logic link_sdi;
  logic [11:0] dac_a_code;
  logic [11:0] dac_b_code;
  logic dac_a_load;
  logic dac_b_load;
  logic fast_settle;
  logic power_down;
  ddwd_vref_e vref_sel;
  int errors;
  int checks_done;
  int aLoads;
  int bLoads;
  int bothLoads;
  ddwd_vref_e refTab [4] = '{VREF_EXTERNAL, VREF_INT_1V024, VREF_INT_2V048, VREF_EXTERNAL};

  dual_dac_word_decoder i_dut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .link_sclk(link_sclk),
    .link_cs_n(link_cs_n),
    .link_sdi(link_sdi),
    .dac_a_code(dac_a_code),
    .dac_b_code(dac_b_code),
    .dac_a_load(dac_a_load),
    .dac_b_load(dac_b_load),
    .fast_settle(fast_settle),
    .power_down(power_down),
    .vref_sel(vref_sel)
  );

  ddwd_host_model i_host (
    .link_sclk(link_sclk),
    .link_cs_n(link_cs_n),
    .link_sdi(link_sdi)
  );

  // Core clock, 10 ns
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Load pulses last one cycle, so count them as they pass
  always @(posedge core_clk) begin
    if (dac_a_load === 1'b1) aLoads++;
    if (dac_b_load === 1'b1) bLoads++;
    if (dac_a_load === 1'b1 && dac_b_load === 1'b1) bothLoads++;
  end

  function automatic logic [15:0] mk(input logic [1:0] sel, input logic settling_speed_bit, input logic power_down_bit,
    input logic [11:0] data);
    return {sel[1], settling_speed_bit, power_down_bit, sel[0], data};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Send, then sample off the rising edge once the core has applied the word
  task automatic send(input logic [31:0] w, input int n);
    i_host.xfer(w, n);
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic expect_all(input logic [11:0] a, input logic [11:0] b, input logic fs,
    input logic pd, input ddwd_vref_e v, input int na, input int nb, input int nab);
    check({4'h0, dac_a_code}, {4'h0, a}, "channel A");
    check({4'h0, dac_b_code}, {4'h0, b}, "channel B");
    check({15'h0000, fast_settle}, {15'h0000, fs}, "speed");
    check({15'h0000, power_down}, {15'h0000, pd}, "power");
    check(16'(vref_sel), 16'(v), "reference");
    check(16'(aLoads), 16'(na), "A loads");
    check(16'(bLoads), 16'(nb), "B loads");
    check(16'(bothLoads), 16'(nab), "joint loads");
    aLoads = 0;
    bLoads = 0;
    bothLoads = 0;
  endtask

  task automatic summarize;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    errors = 0;
    checks_done = 0;
    aLoads = 0;
    bLoads = 0;
    bothLoads = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    expect_all(12'h000, 12'h000, 1'b0, 1'b0, VREF_EXTERNAL, 0, 0, 0);
    // Every reference code, junk in the ignored data bits
    for (int r = 0; r < 4; r++) begin
      send({16'h0000, mk(SEL_CTRL, r[0], 1'b0, {10'h2AA, r[1:0]})}, 16);
      expect_all(12'h000, 12'h000, r[0], 1'b0, refTab[r], 0, 0, 0);
    end
    send({16'h0000, mk(SEL_CTRL, 1'b1, 1'b0, 12'hFFE)}, 16);
    expect_all(12'h000, 12'h000, 1'b1, 1'b0, VREF_INT_2V048, 0, 0, 0);
    // Channel B with buffer; reference must survive data words
    send({16'h0000, mk(SEL_B_AND_BUF, 1'b0, 1'b0, 12'hA5C)}, 16);
    expect_all(12'h000, 12'hA5C, 1'b0, 1'b0, VREF_INT_2V048, 0, 1, 0);
    send({16'h0000, mk(SEL_BUF_ONLY, 1'b1, 1'b0, 12'h123)}, 16);
    expect_all(12'h000, 12'hA5C, 1'b1, 1'b0, VREF_INT_2V048, 0, 0, 0);
    send({16'h0000, mk(SEL_A_AND_B, 1'b1, 1'b0, 12'hFFF)}, 16);
    expect_all(12'hFFF, 12'h123, 1'b1, 1'b0, VREF_INT_2V048, 1, 1, 1);
    // Two words back to back in one frame
    send({mk(SEL_B_AND_BUF, 1'b1, 1'b0, 12'h001), mk(SEL_A_AND_B, 1'b1, 1'b0, 12'h800)}, 32);
    expect_all(12'h800, 12'h001, 1'b1, 1'b0, VREF_INT_2V048, 1, 2, 1);
    // Power-down word ignores all other bits
    send({16'h0000, mk(SEL_B_AND_BUF, 1'b0, 1'b1, 12'h777)}, 16);
    expect_all(12'h800, 12'h001, 1'b1, 1'b1, VREF_INT_2V048, 0, 0, 0);
    send({16'h0000, mk(SEL_BUF_ONLY, 1'b1, 1'b0, 12'h458)}, 16);
    expect_all(12'h800, 12'h001, 1'b1, 1'b0, VREF_INT_2V048, 0, 0, 0);
    // Early select rise: low nibble 8 left over acts as select 10, slow
    send({20'h00000, 12'h9AB}, 12);
    expect_all(12'h9AB, 12'h458, 1'b0, 1'b0, VREF_INT_2V048, 1, 1, 1);
    // Frozen core must hold a finished word until the enable returns
    @(posedge core_clk);
    clk_en <= 1'b0;
    send({16'h0000, mk(SEL_B_AND_BUF, 1'b0, 1'b0, 12'h3C3)}, 16);
    expect_all(12'h9AB, 12'h458, 1'b0, 1'b0, VREF_INT_2V048, 0, 0, 0);
    @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    expect_all(12'h9AB, 12'h3C3, 1'b0, 1'b0, VREF_INT_2V048, 0, 1, 0);
    summarize();
  end
endmodule

`default_nettype wire
